// >>> lpm_regs.vh
// Constants for the LIN physical layer mode and wake-up control block.
`ifndef LPM_REGS_VH
`define LPM_REGS_VH
// Operating mode encodings on the mode_q output.
`define LPM_MODE_SHUTDOWN 2'h0
`define LPM_MODE_NORMAL   2'h1
`define LPM_MODE_RECEIVE_ONLY_SELECT   2'h2
`define LPM_MODE_STANDBY  2'h3
// Pull-up encodings on pullup_strong.
`define LPM_PU_330K       1'h0
`define LPM_PU_34K        1'h1
// Bus levels.
`define LPM_BUS_DOMINANT  1'h0
`define LPM_BUS_RECESSIVE 1'h1
// Wake filter time in ns and system clock period in ns.
`define LPM_WAKE_FILTER_NS 150000
`define LPM_CLK_PERIOD_NS  5
`define LPM_WAKE_FILTER_CYC \
  ((`LPM_WAKE_FILTER_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS)
`endif

// >>> lpm_wake_filter.v
// Dominant-then-rising-edge wake pattern detector.
`timescale 1ns/1ps
`include "lpm_regs.vh"
module lpm_wake_filter #(
  parameter CNT_W      = 16,
  parameter FILTER_CYC = 30000
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire arm,
  input  wire bus_level,
  output reg  wake_pulse_q
);
  //----------------------------------------------------------------
  // Dominant duration counter
  //----------------------------------------------------------------
  reg [CNT_W-1:0] cnt_q;
  reg             qualified_q;
  reg             prev_level_q;
  wire            dom = (bus_level == `LPM_BUS_DOMINANT);
  wire            rise = dom == 1'b0 && prev_level_q == `LPM_BUS_DOMINANT;

  // Counter saturates so a long dominant stays qualified.
  always @(posedge clk_sys) begin
    if (!rst_n || !arm) begin
      cnt_q        <= {CNT_W{1'b0}};
      qualified_q  <= 1'b0;
      prev_level_q <= `LPM_BUS_RECESSIVE;
      wake_pulse_q <= 1'b0;
    end else begin
      prev_level_q <= bus_level;
      wake_pulse_q <= rise && qualified_q;
      if (dom) begin
        if (cnt_q != FILTER_CYC[CNT_W-1:0]) begin
          cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (cnt_q == FILTER_CYC[CNT_W-1:0]) begin
          qualified_q <= 1'b1;
        end
      end else begin
        cnt_q       <= {CNT_W{1'b0}};
        qualified_q <= 1'b0;
      end
    end
  end
endmodule // lpm_wake_filter

// >>> lpm_mode_ctrl.v
// Mode, pull-up and wake-up control of a LIN physical layer.
// What this block does
// - Normal mode enables both receiver and transmitter.
// - Receive-only mode disables the transmitter, receiver at full power.
// - Standby disables the transmitter and puts the receiver in low power.
// - With wake enabled in standby, a long dominant then rising edge wakes.
// - With wake disabled, standby has no wake detection, like shutdown.
// - Leaving stop returns to receive-only if selected, else normal.
// - Pull-up select works only with wake enabled; else 330 kohm forced.
// - Stop ending while dominant restores receive routing to the SCI.
`timescale 1ns/1ps
`include "lpm_regs.vh"
module lpm_mode_ctrl #(
  parameter CNT_W      = 16,
  parameter FILTER_CYC = `LPM_WAKE_FILTER_CYC
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       stop_req,
  input  wire       wake_detect_enable,
  input  wire       pullup_strength_select,
  input  wire       receive_only_select,
  input  wire       lin_rx_level,
  output reg        tx_enable_q,
  output reg        rx_enable_q,
  output reg        rx_low_power_q,
  output reg        pullup_strong_q,
  output reg        rx_route_sci_q,
  output reg        phy_receive_data,
  output reg  [1:0] mode_q,
  output wire       wake_pulse
);
  //----------------------------------------------------------------
  // Mode selection
  //----------------------------------------------------------------
  reg [1:0] mode_d;

  // Stop picks standby or shutdown; leaving stop picks the run mode.
  always @* begin
    if (stop_req) begin
      mode_d = wake_detect_enable ? `LPM_MODE_STANDBY
                                  : `LPM_MODE_SHUTDOWN;
    end else if (receive_only_select) begin
      mode_d = `LPM_MODE_RECEIVE_ONLY_SELECT;
    end else begin
      mode_d = `LPM_MODE_NORMAL;
    end
  end

  // Enables follow the mode; routing returns even if the bus is dominant.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_q           <= `LPM_MODE_NORMAL;
      tx_enable_q      <= 1'b0;
      rx_enable_q      <= 1'b0;
      rx_low_power_q   <= 1'b0;
      rx_route_sci_q   <= 1'b0;
      pullup_strong_q  <= `LPM_PU_330K;
      phy_receive_data <= `LPM_BUS_RECESSIVE;
    end else begin
      mode_q <= mode_d;
      case (mode_d)
        `LPM_MODE_NORMAL: begin
          tx_enable_q    <= 1'b1;
          rx_enable_q    <= 1'b1;
          rx_low_power_q <= 1'b0;
          rx_route_sci_q <= 1'b1;
        end
        `LPM_MODE_RECEIVE_ONLY_SELECT: begin
          tx_enable_q    <= 1'b0;
          rx_enable_q    <= 1'b1;
          rx_low_power_q <= 1'b0;
          rx_route_sci_q <= 1'b1;
        end
        `LPM_MODE_STANDBY: begin
          tx_enable_q    <= 1'b0;
          rx_enable_q    <= 1'b1;
          rx_low_power_q <= 1'b1;
          rx_route_sci_q <= 1'b0;
        end
        default: begin
          tx_enable_q    <= 1'b0;
          rx_enable_q    <= 1'b0;
          rx_low_power_q <= 1'b1;
          rx_route_sci_q <= 1'b0;
        end
      endcase
      pullup_strong_q <= wake_detect_enable ? pullup_strength_select
                                            : `LPM_PU_330K;
      // In standby the line idles recessive so the SCI sees only pulses.
      phy_receive_data <= (mode_d == `LPM_MODE_NORMAL ||
                           mode_d == `LPM_MODE_RECEIVE_ONLY_SELECT) ? lin_rx_level
                          : `LPM_BUS_RECESSIVE;
    end
  end

  //----------------------------------------------------------------
  // Wake detection
  //----------------------------------------------------------------
  wire arm = (mode_q == `LPM_MODE_STANDBY) && wake_detect_enable;

  lpm_wake_filter #(
    .CNT_W      (CNT_W),
    .FILTER_CYC (FILTER_CYC)
  ) u_filter (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .arm          (arm),
    .bus_level    (lin_rx_level),
    .wake_pulse_q (wake_pulse)
  );
endmodule // lpm_mode_ctrl

// >>> lpm_mode_props.sv
// Assertions on the mode, pull-up and wake outputs of the LIN mode block.
`timescale 1ns/1ps
module lpm_mode_props #(
  parameter CNT_W      = 16,
  parameter FILTER_CYC = 30000
) (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       stop_req,
  input wire       wake_detect_enable,
  input wire       pullup_strength_select,
  input wire       lin_rx_level,
  input wire       receive_only_select,
  input wire       tx_enable_q,
  input wire       rx_enable_q,
  input wire       rx_low_power_q,
  input wire       pullup_strong_q,
  input wire [1:0] mode_q,
  input wire       wake_pulse
);
  reg [1:0] up_q;
  // Samples taken in reset are stale, so wait two edges after release.
  always @(posedge clk_sys) up_q <= rst_n ? {up_q[0], 1'h1} : 2'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !up_q[1]);
  norm_paths_a: assert property (
    mode_q == 2'h1 |-> tx_enable_q && rx_enable_q) else $error("paths off");
  rx_only_a: assert property (
    mode_q == 2'h2 |-> !tx_enable_q && rx_enable_q && !rx_low_power_q)
    else $error("bad rx only");
  standby_quiet_a: assert property (
    mode_q == 2'h3 |-> !tx_enable_q && rx_low_power_q) else $error("standby");
  stop_mode_a: assert property (
    $past(stop_req) |-> mode_q == ($past(wake_detect_enable) ? 2'h3 : 2'h0))
    else $error("stop mode");
  run_mode_a: assert property (
    !$past(stop_req) |-> mode_q == ($past(receive_only_select) ? 2'h2 : 2'h1))
    else $error("run mode");
  pullup_sel_a: assert property (
    pullup_strong_q == ($past(wake_detect_enable)
    && $past(pullup_strength_select))) else $error("pull-up");
  pulse_once_a: assert property (
    wake_pulse |=> !wake_pulse) else $error("long pulse");
  wake_edge_a: assert property (
    $rose(wake_pulse) |-> $past(lin_rx_level) && !$past(lin_rx_level, 2)
    && $past(wake_detect_enable)) else $error("stray wake");
endmodule // lpm_mode_props
bind lpm_mode_ctrl lpm_mode_props #(.CNT_W(CNT_W), .FILTER_CYC(FILTER_CYC))
  props (.*);

// >>> lpm_lin_model.sv
// LIN bus driver that also counts wakes as the serial controller would.
`timescale 1ns/1ps
module lpm_lin_model (
  input  wire       clk_sys,
  input  wire       wake_pulse,
  output reg        lin_level,
  output reg  [3:0] wakes_q
);
  // The idle bus rests recessive on its pull-up.
  initial {lin_level, wakes_q} = 5'h10;
  // Only the wake_pulse output can wake the controller.
  always @(posedge clk_sys) if (wake_pulse === 1'h1) wakes_q <= wakes_q + 4'h1;
  // Dominant for n cycles, then released with a rising edge.
  task dom(input integer n); begin
    lin_level = 1'h0;
    repeat (n) @(posedge clk_sys);
    #1 lin_level = 1'h1;
  end endtask
endmodule // lpm_lin_model

// >>> testbench.sv
// Self-checking bench of the LIN mode and wake-up block.
`timescale 1ns/1ps
module testbench;
  reg        clk_sys = 1'h0;
  reg        rst_n = 1'h0;
  reg  [3:0] cfg = 4'h0;
  integer    num_errors = 0;
  integer    comparisons = 0;
  integer    i;
  wire       lin, wake, tx, rx, pull, route, prd, lowp;
  wire [1:0] mode;
  wire [3:0] wakes;
  always #2.5 clk_sys = ~clk_sys;
  lpm_lin_model bus (.clk_sys(clk_sys), .wake_pulse(wake), .lin_level(lin),
    .wakes_q(wakes));
  lpm_mode_ctrl #(.CNT_W(4), .FILTER_CYC(8)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .stop_req(cfg[3]), .wake_detect_enable(cfg[2]),
    .pullup_strength_select(cfg[1]), .receive_only_select(cfg[0]),
    .lin_rx_level(lin), .tx_enable_q(tx), .rx_enable_q(rx),
    .rx_low_power_q(lowp), .pullup_strong_q(pull), .rx_route_sci_q(route),
    .phy_receive_data(prd), .mode_q(mode), .wake_pulse(wake));
  task chk(input [3:0] got, input [3:0] exp); begin
    comparisons = comparisons + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  task give_verdict; begin
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  // Every stop, wake, pull-up and receive-only setting in turn.
  task modes; begin
    for (i = 0; i < 16; i = i + 1) begin
      cfg = i[3:0];
      repeat (2) @(posedge clk_sys);
      #1 chk({2'h0, mode}, cfg[3] ? {3'h0, cfg[2]} * 4'h3 : 4'h1 + cfg[0]);
      chk({tx, rx, lowp, pull}, {!cfg[3] & !cfg[0], !cfg[3] | cfg[2], cfg[3], cfg[2] & cfg[1]});
      chk({2'h0, route, prd}, {2'h0, !cfg[3], 1'h1});
    end
  end endtask
  // One dominant burst of n cycles, then the running wake count.
  task wake_seq(input [3:0] c, input integer n, input [3:0] exp); begin
    cfg = c;
    repeat (3) @(posedge clk_sys);
    #1 bus.dom(n);
    repeat (3) @(posedge clk_sys);
    #1 chk(wakes, exp);
  end endtask
  // Stop ends while the bus is still dominant.
  task exit_dom; begin
    cfg = 4'hc;
    fork
      bus.dom(8);
      #12 cfg = 4'h0;
      #23 chk({2'h0, route, prd}, 4'h2);
    join
  end endtask
  initial begin
    #20000;
    num_errors = num_errors + 1;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'h1;
    modes;
    wake_seq(4'hc, 10, 4'h1);
    wake_seq(4'hc, 6, 4'h1);
    wake_seq(4'h8, 12, 4'h1);
    wake_seq(4'hc, 10, 4'h2);
    exit_dom;
    give_verdict;
  end
endmodule // testbench
